// ---- core/adcr_regs.sv ----
// Serial configuration register bank with output data formatting and overrange
`timescale 1ns/1ps
`include "adcr_params.svh"

module adcr_regs #(
  parameter logic [7:0] PART_ID = 8'h5a, // Arbitrary value
  parameter logic [1:0] GRADE   = 2'h0,
  parameter int         DW      = 16
) (
  // Clock and reset
  input  wire logic          CLK_I,
  input  wire logic          RST_I,
  // Serial port
  input  wire logic          SCLK_I,
  input  wire logic          CSB_N_I,
  input  wire logic          SDIO_I,
  output logic               SDIO_O,
  output logic               SDIO_OE_O,
  // Converter side
  input  wire logic [DW-1:0] SAMPLE_A_I,
  input  wire logic [DW-1:0] SAMPLE_B_I,
  input  wire logic          SAMPLE_VALID_I,
  input  wire logic          ANALOG_TRIP_I,
  input  wire logic          CAL_ACTIVE_I,
  input  wire logic          LOOP_RESET_I,
  input  wire logic          LOOP_LOCKED_I,
  // Data outputs
  output logic [DW-1:0]      D_O,
  output logic               D_OE_O,
  output logic               OR_O,
  // Settings
  output logic [1:0]         POWER_STATE_O,
  output logic               MULTIPLIER_LOOP_ON_O,
  output logic               LOOP_AUTO_BAND_O,
  output logic [5:0]         LOOP_MULTIPLIER_O,
  output logic [1:0]         INPUT_BANDWIDTH_SELECT_O,
  output logic               DRIVE_LOW_SWING_O,
  output logic [3:0]         DRIVE_STRENGTH_O,
  output logic               DCO_INVERT_O,
  output logic               EXTERNAL_REFERENCE_SELECT_O,
  output logic [5:0]         RATE_DIVISOR_O
);

  // ==========================================
  // Functions

  // Raw samples arrive as twos complement
  function automatic logic [DW-1:0] fmt_code(
    input logic [1:0]    fmt,
    input logic [DW-1:0] s
  );
    logic [DW-1:0] ob;
    ob = {~s[DW-1], s[DW-2:0]};
    case (fmt)
      2'h1:    fmt_code = s;
      2'h2:    fmt_code = ob ^ (ob >> 1);
      default: fmt_code = ob;
    endcase
  endfunction

  function automatic logic [12:0] step_addr(
    input logic        up,
    input logic [12:0] a
  );
    step_addr = up ? a + 13'h001 : a - 13'h001;
  endfunction

  // ==========================================
  // Input synchronisers

  logic sclk1_q;
  logic sclk2_q;
  logic sclk3_q;
  logic csb1_q;
  logic csb2_q;
  logic sdi1_q;
  logic sdi2_q;
  logic lock1_q;
  logic lock2_q;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sclk1_q <= 1'b0;
      sclk2_q <= 1'b0;
      sclk3_q <= 1'b0;
      csb1_q  <= 1'b1;
      csb2_q  <= 1'b1;
      sdi1_q  <= 1'b0;
      sdi2_q  <= 1'b0;
      lock1_q <= 1'b0;
      lock2_q <= 1'b0;
    end else begin
      sclk1_q <= SCLK_I;
      sclk2_q <= sclk1_q;
      sclk3_q <= sclk2_q;
      csb1_q  <= CSB_N_I;
      csb2_q  <= csb1_q;
      sdi1_q  <= SDIO_I;
      sdi2_q  <= sdi1_q;
      lock1_q <= LOOP_LOCKED_I;
      lock2_q <= lock1_q;
    end
  end

  wire sclk_rise = sclk2_q & ~sclk3_q;
  wire sclk_fall = ~sclk2_q & sclk3_q;
  wire selected  = ~csb2_q;

  // ==========================================
  // Registers

  logic       low_bit_first_select_q;
  logic [1:0] power_state_q;
  logic       multiplier_loop_on_q;
  logic       loop_auto_band_q;
  logic [5:0] loop_multiplier_q;
  logic [1:0] input_bandwidth_select_q;
  logic [7:0] omode_q;
  logic [3:0] adj_q;
  logic       dco_inv_q;
  logic       external_reference_select_q;
  logic [5:0] rate_divisor_q;
  logic [7:0] ovr_q;

  // ==========================================
  // Serial frame

  adcr_pkg::adcr_state_t st_q;
  adcr_pkg::adcr_state_t st_d;
  logic [15:0] ins_q;
  logic [7:0]  rx_q;
  logic [7:0]  tx_q;
  logic [3:0]  cnt_q;
  logic [12:0] addr_q;
  logic        rd_q;
  logic [1:0]  len_q;
  logic [1:0]  nbytes_q;
  logic        load_pend_q;
  logic [7:0]  rdata;

  wire lsb = low_bit_first_select_q;

  // Bit order applies to instruction and data alike
  wire [15:0] ins_sh = lsb ? {sdi2_q, ins_q[15:1]} : {ins_q[14:0], sdi2_q};
  wire [7:0]  rx_sh  = lsb ? {sdi2_q, rx_q[7:1]} : {rx_q[6:0], sdi2_q};
  wire [7:0]  tx_sh  = lsb ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};

  wire in_instr  = (st_q == adcr_pkg::ADCR_INSTR);
  wire in_data   = (st_q == adcr_pkg::ADCR_DATA);
  wire ins_end   = in_instr & sclk_rise & (cnt_q == `ADCR_INS_BITS);
  wire byte_end  = in_data & sclk_rise & (cnt_q == `ADCR_BYTE_BITS);
  wire wr_fire   = byte_end & ~rd_q;
  wire last_byte = (len_q != `ADCR_LEN_STREAM) & (nbytes_q == len_q);

  always_comb begin
    st_d = st_q;
    case (st_q)
      adcr_pkg::ADCR_IDLE: begin
        if (selected) begin
          st_d = adcr_pkg::ADCR_INSTR;
        end
      end
      adcr_pkg::ADCR_INSTR: begin
        if (ins_end) begin
          st_d = adcr_pkg::ADCR_DATA;
        end
      end
      adcr_pkg::ADCR_DATA: begin
        if (byte_end && last_byte) begin
          st_d = adcr_pkg::ADCR_DONE;
        end
      end
      adcr_pkg::ADCR_DONE: begin
        st_d = adcr_pkg::ADCR_DONE;
      end
      default: begin
        st_d = adcr_pkg::ADCR_IDLE;
      end
    endcase
    if (!selected) begin
      st_d = adcr_pkg::ADCR_IDLE;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st_q <= adcr_pkg::ADCR_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Shift and count on sampled rising edges
  always_ff @(posedge CLK_I) begin
    if (RST_I || !selected) begin
      ins_q    <= 16'h0000;
      rx_q     <= 8'h00;
      cnt_q    <= 4'h0;
      addr_q   <= 13'h0000;
      rd_q     <= 1'b0;
      len_q    <= 2'h0;
      nbytes_q <= 2'h0;
    end else if (ins_end) begin
      ins_q    <= ins_sh;
      cnt_q    <= 4'h0;
      rd_q     <= ins_sh[15];
      len_q    <= ins_sh[14:13];
      addr_q   <= ins_sh[12:0];
    end else if (byte_end) begin
      rx_q     <= rx_sh;
      cnt_q    <= 4'h0;
      nbytes_q <= nbytes_q + 2'h1;
      // Streaming walks up in low-bit-first order, down otherwise
      addr_q   <= step_addr(lsb, addr_q);
    end else if (sclk_rise && in_instr) begin
      ins_q    <= ins_sh;
      cnt_q    <= cnt_q + 4'h1;
    end else if (sclk_rise && in_data) begin
      rx_q     <= rx_sh;
      cnt_q    <= cnt_q + 4'h1;
    end
  end

  // Read data changes on falling edges so it is stable at the next rise
  always_ff @(posedge CLK_I) begin
    if (RST_I || !selected) begin
      tx_q        <= 8'h00;
      load_pend_q <= 1'b0;
    end else if ((ins_end && ins_sh[15]) || (byte_end && rd_q && !last_byte)) begin
      load_pend_q <= 1'b1;
    end else if (sclk_fall && load_pend_q) begin
      tx_q        <= rdata;
      load_pend_q <= 1'b0;
    end else if (sclk_fall && in_data && rd_q) begin
      tx_q        <= tx_sh;
    end
  end

  assign SDIO_O    = lsb ? tx_q[0] : tx_q[7];
  assign SDIO_OE_O = selected & in_data & rd_q;

  // ==========================================
  // Register writes

  wire wr_setup = wr_fire & (addr_q == `ADCR_A_SETUP);
  wire wr_pwr   = wr_fire & (addr_q == `ADCR_A_PWR);
  wire wr_lpen  = wr_fire & (addr_q == `ADCR_A_LOOPEN);
  wire wr_loop  = wr_fire & (addr_q == `ADCR_A_LOOP);
  wire wr_bw    = wr_fire & (addr_q == `ADCR_A_BW);
  wire wr_omode = wr_fire & (addr_q == `ADCR_A_OMODE);
  wire wr_adj   = wr_fire & (addr_q == `ADCR_A_ADJ);
  wire wr_dco   = wr_fire & (addr_q == `ADCR_A_DCO);
  wire wr_ref   = wr_fire & (addr_q == `ADCR_A_REF);
  wire wr_div   = wr_fire & (addr_q == `ADCR_A_DIV);
  wire wr_ovr   = wr_fire & (addr_q == `ADCR_A_OVR);

  wire soft_rst = wr_setup & (rx_sh[5] | rx_sh[2]);

  // Either mirror bit sets the order
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      low_bit_first_select_q <= 1'b0;
    end else if (wr_setup) begin
      low_bit_first_select_q <= rx_sh[6] | rx_sh[1];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      multiplier_loop_on_q <= 1'b0;
      loop_auto_band_q     <= 1'b0;
      loop_multiplier_q    <= 6'h00;
    end else begin
      if (wr_lpen) begin
        multiplier_loop_on_q <= rx_sh[2];
      end
      if (wr_loop) begin
        loop_auto_band_q  <= rx_sh[6];
        loop_multiplier_q <= rx_sh[5:0];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || soft_rst) begin
      power_state_q               <= 2'h0;
      input_bandwidth_select_q    <= 2'h0;
      omode_q                     <= 8'h00;
      adj_q                       <= `ADCR_ADJ_RST;
      dco_inv_q                   <= 1'b0;
      external_reference_select_q <= 1'b0;
      rate_divisor_q              <= 6'h00;
      ovr_q                       <= 8'h00;
    end else begin
      if (wr_pwr) begin
        power_state_q <= rx_sh[1:0];
      end
      if (wr_bw) begin
        input_bandwidth_select_q <= rx_sh[6:5];
      end
      if (wr_omode) begin
        omode_q <= rx_sh & `ADCR_OMODE_MASK;
      end
      if (wr_adj) begin
        adj_q <= rx_sh[3:0];
      end
      if (wr_dco) begin
        dco_inv_q <= rx_sh[7];
      end
      if (wr_ref) begin
        external_reference_select_q <= rx_sh[6];
      end
      if (wr_div) begin
        rate_divisor_q <= rx_sh[5:0];
      end
      if (wr_ovr) begin
        ovr_q <= rx_sh;
      end
    end
  end

  // ==========================================
  // Register reads

  // Unmapped offsets read zero
  always_comb begin
    case (addr_q)
      // Mirrored order bits around fixed ones
      `ADCR_A_SETUP:  rdata = `ADCR_SETUP_FIXED | {1'b0, lsb, 4'h0, lsb, 1'b0};
      `ADCR_A_ID:     rdata = PART_ID;
      `ADCR_A_GRADE:  rdata = {2'h0, GRADE, 4'h0};
      `ADCR_A_PWR:    rdata = {6'h00, power_state_q};
      `ADCR_A_LOOPEN: rdata = {5'h00, multiplier_loop_on_q, 2'h0};
      // Lock flag from the synchronised status
      `ADCR_A_LOOP:   rdata = {lock2_q, loop_auto_band_q, loop_multiplier_q};
      `ADCR_A_BW:     rdata = {1'b0, input_bandwidth_select_q, 5'h00};
      `ADCR_A_OMODE:  rdata = omode_q;
      `ADCR_A_ADJ:    rdata = {4'h0, adj_q};
      `ADCR_A_DCO:    rdata = {dco_inv_q, 7'h00};
      `ADCR_A_REF:    rdata = {1'b0, external_reference_select_q, 6'h00};
      `ADCR_A_DIV:    rdata = {2'h0, rate_divisor_q};
      `ADCR_A_OVR:    rdata = ovr_q;
      default:        rdata = 8'h00;
    endcase
  end

  // ==========================================
  // Output data path

  wire       interleave    = omode_q[5];
  wire       output_disable = omode_q[4];
  wire       output_invert = omode_q[2];
  wire [1:0] fmt           = omode_q[1:0];
  wire       loop_reset_indicate = ovr_q[7];
  wire       overrange_mode_select = ovr_q[6];
  wire [5:0] overrange_threshold = ovr_q[5:0];

  logic          ch_q;
  logic [DW-1:0] d_q;
  logic          or_q;

  // Channels alternate per sample when interleaved
  wire [DW-1:0] smp = (interleave && ch_q) ? SAMPLE_B_I : SAMPLE_A_I;
  wire [DW-1:0] ob  = {~smp[DW-1], smp[DW-2:0]};

  wire [DW-1:0] code = fmt_code(fmt, smp) ^ {DW{output_invert}};

  // Threshold scales onto the top code bits
  wire [DW-1:0] thr_code = {overrange_threshold, {(DW-6){1'b0}}};
  wire          dig_trip = ob > `ADCR_OR_FULL;
  wire          thr_trip = ob > thr_code;
  wire          any_trip = ANALOG_TRIP_I | dig_trip;
  wire          dv_mode  = overrange_mode_select & (overrange_threshold == 6'h01);
  wire          rst_evt  = loop_reset_indicate & LOOP_RESET_I;

  wire or_dig  = (overrange_threshold == 6'h00) ? dig_trip : thr_trip;
  wire or_full = dv_mode ? ~(any_trip | CAL_ACTIVE_I) : any_trip;
  wire or_base = overrange_mode_select ? or_full : or_dig;
  // Loop reset shows as overrange, or as not-valid
  wire or_d    = dv_mode ? (or_base & ~rst_evt) : (or_base | rst_evt);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ch_q <= 1'b0;
      d_q  <= {DW{1'b0}};
      or_q <= 1'b0;
    end else if (SAMPLE_VALID_I) begin
      ch_q <= interleave & ~ch_q;
      d_q  <= code;
      or_q <= or_d;
    end
  end

  assign D_O    = d_q;
  assign D_OE_O = ~output_disable;
  assign OR_O   = or_q;

  // ==========================================
  // Setting outputs

  assign POWER_STATE_O               = power_state_q;
  assign MULTIPLIER_LOOP_ON_O        = multiplier_loop_on_q;
  assign LOOP_AUTO_BAND_O            = loop_auto_band_q;
  assign LOOP_MULTIPLIER_O           = loop_multiplier_q;
  assign INPUT_BANDWIDTH_SELECT_O    = input_bandwidth_select_q;
  assign DRIVE_LOW_SWING_O           = omode_q[7];
  assign DRIVE_STRENGTH_O            = adj_q;
  assign DCO_INVERT_O                = dco_inv_q;
  assign EXTERNAL_REFERENCE_SELECT_O = external_reference_select_q;
  assign RATE_DIVISOR_O              = rate_divisor_q;

endmodule

// ---- core/adcr_params.svh ----
// Register map, field positions, reset values and serial framing constants
// How it works
// - Port setup bits 6 and 1 mirror bit order; zero is high bit first.
// - Writing ones to bits 5 or 2 restores defaults except setup and loop registers.
// - Grade field bits 5:4 of register 0x02 reads zero for the widest grade.
// - Power field bits 1:0 of 0x08: normal, power-down, standby, sleep.
// - Bit 7 of 0x0A reads the multiplier loop lock status.
// - 0x0A holds autoband bit 6 and multiplier 5:0; 0x09 bit 2 enables loop.
// - Output mode bit 5 interleaves both channels onto the data bus.
// - Output mode bit 4 releases the data bus; zero drives it.
// - Output mode bit 2 inverts every data bit.
// - Bit 6 of 0x18 selects the external reference.
// - Bits 5:0 of 0x101 set the output rate divisor.
// - Bit 7 of 0x111 adds loop reset events onto the overrange pin.
// - Mode and threshold zero: overrange high while code exceeds 32767.
// - Mode zero, threshold nonzero: overrange high while code exceeds threshold.
// - Mode one, threshold zero: overrange high on analog or digital trip.
// - Mode one, threshold one: data valid, low on trips or calibration.
`ifndef ADCR_PARAMS_SVH
`define ADCR_PARAMS_SVH

// ==========================================
// Offsets
`define ADCR_A_SETUP  13'h000
`define ADCR_A_ID     13'h001
`define ADCR_A_GRADE  13'h002
`define ADCR_A_PWR    13'h008
`define ADCR_A_LOOPEN 13'h009
`define ADCR_A_LOOP   13'h00a
`define ADCR_A_BW     13'h00f
`define ADCR_A_OMODE  13'h014
`define ADCR_A_ADJ    13'h015
`define ADCR_A_DCO    13'h016
`define ADCR_A_REF    13'h018
`define ADCR_A_DIV    13'h101
`define ADCR_A_OVR    13'h111

// ==========================================
// Fields and reset values
`define ADCR_SETUP_FIXED 8'h18
`define ADCR_OMODE_MASK  8'hb7
`define ADCR_ADJ_RST     4'h2
`define ADCR_OR_FULL     16'h7fff
`define ADCR_INS_BITS    4'hf
`define ADCR_BYTE_BITS   4'h7
`define ADCR_LEN_STREAM  2'h3

`endif

// ---- core/adcr_pkg.sv ----
// Types shared by the configuration register bank
package adcr_pkg;

  // Serial frame states, one-hot
  typedef enum logic [3:0] {
    ADCR_IDLE  = 4'h1,
    ADCR_INSTR = 4'h2,
    ADCR_DATA  = 4'h4,
    ADCR_DONE  = 4'h8
  } adcr_state_t;

endpackage

// ---- testbench/adcr_regs_sva.sv ----
// Port assertions for the configuration register bank
`timescale 1ns/1ps
module adcr_regs_sva #(
  parameter int DW = 16
) (
  input wire logic          CLK_I,
  input wire logic          RST_I,
  input wire logic          SCLK_I,
  input wire logic          CSB_N_I,
  input wire logic          SDIO_O,
  input wire logic          SDIO_OE_O,
  input wire logic [DW-1:0] SAMPLE_A_I,
  input wire logic          SAMPLE_VALID_I,
  input wire logic [DW-1:0] D_O,
  input wire logic          D_OE_O,
  input wire logic          OR_O,
  input wire logic [1:0]    POWER_STATE_O,
  input wire logic          MULTIPLIER_LOOP_ON_O,
  input wire logic [5:0]    LOOP_MULTIPLIER_O,
  input wire logic [3:0]    DRIVE_STRENGTH_O,
  input wire logic [5:0]    RATE_DIVISOR_O
);
  // ==========
  // Helpers
  logic          seen_q;
  logic [DW-1:0] ob_w;
  logic          hi_w;
  // Default format only holds until the first frame may have changed it
  assign ob_w = SAMPLE_A_I ^ {1'b1, {(DW-1){1'b0}}};
  assign hi_w = ob_w[DW-1];
  always_ff @(posedge CLK_I) begin
    seen_q <= RST_I ? 1'b0 : (seen_q | !CSB_N_I);
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ==========
  // Properties
  a_reset_defaults:
    assert property ($fell(RST_I) |-> POWER_STATE_O == 2'h0 && !MULTIPLIER_LOOP_ON_O && LOOP_MULTIPLIER_O == 6'h00
      && RATE_DIVISOR_O == 6'h00 && DRIVE_STRENGTH_O == 4'h2 && D_OE_O && !SDIO_OE_O)
    else $error("settings not at defaults after reset");
  a_settings_in_frame:
    assert property (!$stable({POWER_STATE_O, LOOP_MULTIPLIER_O, RATE_DIVISOR_O, D_OE_O})
      |-> !CSB_N_I || !$past(CSB_N_I, 4))
    else $error("setting changed outside a frame");
  a_data_cause:
    assert property (!$stable(D_O) |-> $past(SAMPLE_VALID_I)) else $error("data changed without a sample");
  a_or_cause:
    assert property (!$stable(OR_O) |-> $past(SAMPLE_VALID_I)) else $error("overrange changed without a sample");
  a_default_format:
    assert property (SAMPLE_VALID_I && !seen_q |=> D_O == $past(ob_w)) else $error("default format wrong");
  a_default_or:
    assert property (SAMPLE_VALID_I && !seen_q |=> OR_O == $past(hi_w)) else $error("default overrange wrong");
  a_sdio_hold:
    assert property ($rose(SCLK_I) && SDIO_OE_O |=> $stable(SDIO_O) [*4]) else $error("read bit moved");
  a_sdio_release:
    assert property (CSB_N_I [*6] |-> !SDIO_OE_O) else $error("read driver left on");
endmodule

bind adcr_regs adcr_regs_sva #(.DW(DW)) u_sva (
  .CLK_I(CLK_I), .RST_I(RST_I), .SCLK_I(SCLK_I), .CSB_N_I(CSB_N_I), .SDIO_O(SDIO_O), .SDIO_OE_O(SDIO_OE_O),
  .SAMPLE_A_I(SAMPLE_A_I), .SAMPLE_VALID_I(SAMPLE_VALID_I), .D_O(D_O), .D_OE_O(D_OE_O), .OR_O(OR_O),
  .POWER_STATE_O(POWER_STATE_O), .MULTIPLIER_LOOP_ON_O(MULTIPLIER_LOOP_ON_O),
  .LOOP_MULTIPLIER_O(LOOP_MULTIPLIER_O), .DRIVE_STRENGTH_O(DRIVE_STRENGTH_O), .RATE_DIVISOR_O(RATE_DIVISOR_O));

// ---- testbench/adcr_host.sv ----
// Host controller model for the three-wire serial port
`timescale 1ns/1ps
module adcr_host (
  // Clock
  input  wire logic clk_i,
  // Serial port
  input  wire logic sdio_i,
  input  wire logic sdio_oe_i,
  output logic      sclk_o,
  output logic      csb_n_o,
  output logic      line_o
);
  logic drv_q;
  logic bit_q;
  initial begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    drv_q = 1'b1;
    bit_q = 1'b0;
  end
  // Released line shows the inverse of the last bit so stale data cannot pass
  assign line_o = sdio_oe_i ? sdio_i : (drv_q ? bit_q : ~bit_q);
  task automatic xfer(input logic lsb, input logic rd, input logic [12:0] a, input logic [7:0] wd,
                      output logic [7:0] q);
    logic [23:0] w;
    int          i;
    w = {rd, 2'h0, a, wd};
    q = 8'h00;
    @(posedge clk_i) csb_n_o <= 1'b0;
    for (i = 0; i < 24; i++) begin
      repeat (4) @(posedge clk_i);
      if (!rd || i < 16) bit_q <= w[lsb ? (i < 16 ? i + 8 : i - 16) : 23 - i];
      drv_q <= !rd || i < 16;
      sclk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      if (i >= 16) q[lsb ? i - 16 : 23 - i] = line_o;
    end
    repeat (4) @(posedge clk_i);
    sclk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    csb_n_o <= 1'b1;
    drv_q <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// ---- testbench/adcr_regs_test.sv ----
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module adcr_regs_test;
  // ==========
  // Signals
  localparam logic [7:0] ID = 8'h3c; // Arbitrary value
  logic        clk, rst, vld, atrip, cal, lrst, locked, lsb, sclk, csb_n, line, sdo, sdo_oe, d_oe, ovr;
  logic        lon, lab, eref, dls, dci;
  logic [15:0] sa, sb, d;
  logic [1:0]  pwr, bw;
  logic [5:0]  mult, div;
  logic [3:0]  drv;
  int          n_fail, compares, cyc, i;
  logic [12:0] ra [14] = '{13'h000, 13'h001, 13'h002, 13'h008, 13'h009, 13'h00a, 13'h00f, 13'h014, 13'h015,
                           13'h016, 13'h018, 13'h101, 13'h111, 13'h1ff};
  logic [7:0]  rv [14] = '{8'h18, ID, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h00};
  logic [7:0]  om [4]  = '{8'h01, 8'h02, 8'h03, 8'h04};
  logic [15:0] oe [4]  = '{16'h1234, 16'h9234 ^ 16'h491a, 16'h9234, ~16'h9234};

  adcr_regs #(.PART_ID(ID)) dut (
    .CLK_I(clk), .RST_I(rst), .SCLK_I(sclk), .CSB_N_I(csb_n), .SDIO_I(line), .SDIO_O(sdo), .SDIO_OE_O(sdo_oe),
    .SAMPLE_A_I(sa), .SAMPLE_B_I(sb), .SAMPLE_VALID_I(vld), .ANALOG_TRIP_I(atrip), .CAL_ACTIVE_I(cal),
    .LOOP_RESET_I(lrst), .LOOP_LOCKED_I(locked), .D_O(d), .D_OE_O(d_oe), .OR_O(ovr), .POWER_STATE_O(pwr),
    .MULTIPLIER_LOOP_ON_O(lon), .LOOP_AUTO_BAND_O(lab), .LOOP_MULTIPLIER_O(mult), .INPUT_BANDWIDTH_SELECT_O(bw),
    .DRIVE_LOW_SWING_O(dls), .DRIVE_STRENGTH_O(drv), .DCO_INVERT_O(dci), .EXTERNAL_REFERENCE_SELECT_O(eref),
    .RATE_DIVISOR_O(div));
  adcr_host host (.clk_i(clk), .sdio_i(sdo), .sdio_oe_i(sdo_oe), .sclk_o(sclk), .csb_n_o(csb_n), .line_o(line));

  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    logic [7:0] q;
    host.xfer(lsb, 1'b0, a, v, q);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer(lsb, 1'b1, a, 8'h00, q);
    chk($sformatf("reg %h", a), {8'h00, q}, {8'h00, e});
  endtask
  task automatic smp(input logic [15:0] a, input logic [15:0] b, input logic [15:0] ed, input logic eo);
    @(posedge clk) begin
      sa <= a;
      sb <= b;
      vld <= 1'b1;
    end
    @(posedge clk) vld <= 1'b0;
    @(negedge clk);
    chk("data", d, ed);
    chk("overrange", {15'h0, ovr}, {15'h0, eo});
  endtask
  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========
  // Clock, timeout and sequence
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    {rst, vld, atrip, cal, lrst, locked, lsb, sa, sb} = {1'b1, 38'h0};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    smp(16'h7fff, 16'h0, 16'hffff, 1'b1);
    smp(16'h8000, 16'h0, 16'h0000, 1'b0);
    for (i = 0; i < 14; i++) rd(ra[i], rv[i]);
    for (i = 0; i < 4; i++) begin
      wr(13'h008, 8'(i));
      chk("power", {14'h0, pwr}, 16'(i));
      wr(13'h00f, 8'(i << 5));
      chk("bandwidth", {14'h0, bw}, 16'(i));
    end
    wr(13'h009, 8'h04);
    wr(13'h00a, 8'hff);
    rd(13'h00a, 8'h7f);
    chk("loop", {8'h0, lon, lab, mult}, 16'h00ff);
    @(posedge clk) locked <= 1'b1;
    rd(13'h00a, 8'hff);
    wr(13'h018, 8'h40);
    wr(13'h101, 8'h2a);
    chk("ref_div", {9'h0, eref, div}, 16'h006a);
    wr(13'h002, 8'hff);
    rd(13'h002, 8'h00);
    wr(13'h015, 8'h0c);
    wr(13'h016, 8'h80);
    wr(13'h014, 8'h80);
    chk("drive_set", {8'h0, dls, dci, 2'h0, drv}, 16'h00cc);
    wr(13'h000, 8'h24);
    rd(13'h008, 8'h00);
    rd(13'h101, 8'h00);
    rd(13'h009, 8'h04);
    rd(13'h00a, 8'hff);
    rd(13'h000, 8'h18);
    rd(13'h015, 8'h02);
    rd(13'h014, 8'h00);
    chk("drive_set", {8'h0, dls, dci, 2'h0, drv}, 16'h0002);
    wr(13'h000, 8'h42);
    lsb = 1'b1;
    rd(13'h000, 8'h5a);
    wr(13'h008, 8'h01);
    chk("power", {14'h0, pwr}, 16'h0001);
    wr(13'h000, 8'h00);
    lsb = 1'b0;
    rd(13'h008, 8'h01);
    for (i = 0; i < 4; i++) begin
      wr(13'h014, om[i]);
      smp(16'h1234, 16'h0, oe[i], 1'b1);
    end
    wr(13'h014, 8'h20);
    smp(16'h1234, 16'h0001, 16'h9234, 1'b1);
    smp(16'h1234, 16'h0001, 16'h8001, 1'b1);
    wr(13'h014, 8'h10);
    chk("drive", {15'h0, d_oe}, 16'h0000);
    wr(13'h014, 8'h00);
    chk("drive", {15'h0, d_oe}, 16'h0001);
    wr(13'h111, 8'h01);
    smp(16'h8401, 16'h0, 16'h0401, 1'b1);
    smp(16'h8400, 16'h0, 16'h0400, 1'b0);
    wr(13'h111, 8'h40);
    @(posedge clk) atrip <= 1'b1;
    smp(16'h8000, 16'h0, 16'h0000, 1'b1);
    @(posedge clk) atrip <= 1'b0;
    smp(16'h8000, 16'h0, 16'h0000, 1'b0);
    wr(13'h111, 8'h41);
    @(posedge clk) cal <= 1'b1;
    smp(16'h8000, 16'h0, 16'h0000, 1'b0);
    @(posedge clk) cal <= 1'b0;
    smp(16'h8000, 16'h0, 16'h0000, 1'b1);
    wr(13'h111, 8'h80);
    @(posedge clk) lrst <= 1'b1;
    smp(16'h8000, 16'h0, 16'h0000, 1'b1);
    // Reset again with settings away from their defaults
    @(posedge clk) rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(13'h008, 8'h00);
    rd(13'h00a, 8'h80);
    rd(13'h000, 8'h18);
    results();
  end
endmodule
